// *** core/pwm_ctrl_consts.svh ***
// Summary of operation
// (RULE1) Shutdown-group bits 3..0 mark channels 4..1 as members when set.
// (RULE2) Leaving shutdown with hold bit clear, members stay stopped; others start.
// (RULE3) Soft ramp runs on shutdown entry/exit and on power-down input changes.
// (RULE4) Period code upper bits 001 skips the 50% duty interval entirely.
// (RULE5) Codes 01000..01111 give 16.5..125.7 ms; 01111 is the reset default.
// (RULE6) Codes 10000..11111 give 164.6..13196.4 ms intervals.
// (RULE7) Internal oscillator enables clock-rate detection without an external reference.
// (RULE8) Writing 0x00 to trim register 0x1B selects the factory trim value.
// (RULE9) Host runs the trim after every reset before trusting rate detection.
// (RULE10) Trim register bit 6 is read-only; reads one once trimming is done.
// (RULE11) Trim bit 1 resets to one; writing zero selects factory trim.
// (RULE12) Host writes reserved bits only with their default values.
`ifndef PWM_CTRL_CONSTS_SVH
`define PWM_CTRL_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_SHUTDOWN_GROUP 8'h19
`define ADDR_SOFT_PERIOD 8'h1A
`define ADDR_OSC_TRIM 8'h1B
`define RST_SHUTDOWN_GROUP 8'h30
`define RST_SOFT_PERIOD 8'h6F
`define RST_OSC_TRIM 8'h82
`define BIT_TIMER_DISABLE 7
`define BIT_TRIM_DONE 6
`define BIT_FACTORY_OFF 1
`define SKIP_CODE_TOP 3'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define TENTH_MS_NS 100000
`define TRIM_CYCLES 8'h40

// ----------------------------------------
// ramp lengths in tenths of a millisecond
// ----------------------------------------
`define SS_T08 18'h000A5
`define SS_T09 18'h000EF
`define SS_T0A 18'h0013A
`define SS_T0B 18'h00194
`define SS_T0C 18'h0021B
`define SS_T0D 18'h002BF
`define SS_T0E 18'h003AE
`define SS_T0F 18'h004E9
`define SS_T10 18'h0066E
`define SS_T11 18'h0095A
`define SS_T12 18'h00C46
`define SS_T13 18'h00FC7
`define SS_T14 18'h0150A
`define SS_T15 18'h01B77
`define SS_T16 18'h024D1
`define SS_T17 18'h03116
`define SS_T18 18'h04381
`define SS_T19 18'h06230
`define SS_T1A 18'h080DF
`define SS_T1B 18'h0A5B1
`define SS_T1C 18'h0DCEC
`define SS_T1D 18'h1206D
`define SS_T1E 18'h1829D
`define SS_T1F 18'h2037C

`endif

// *** core/pwm_ctrl_pkg.sv ***
package pwm_ctrl_pkg;
   typedef enum logic [1:0] {
      ST_DOWN,
      ST_RAMP_UP,
      ST_RUN,
      ST_RAMP_DOWN
   } seq_state_type;
   typedef logic [7:0] reg_byte_type;
   typedef logic [17:0] tenths_type;
endpackage

// *** core/pwm_shutdown_softstart_trim.sv ***
`include "pwm_ctrl_consts.svh"
module pwm_shutdown_softstart_trim
   import pwm_ctrl_pkg::*;
#(
   parameter int unsigned CYCLES_PER_TENTH = `TENTH_MS_NS / `CLK_PERIOD_NS,
   parameter logic [7:0] DEFAULT_TRIM = 8'h80
) (
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic ALL_SHUTDOWN_I,
   input wire logic HOLD_GROUP_I,
   input wire logic POWER_DOWN_INPUT_I,
   input wire logic [7:0] FACTORY_TRIM_I,
   output logic [3:0] CH_RUN_O,
   output logic HALF_DUTY_O,
   output logic [7:0] OSC_TRIM_O,
   output logic FACTORY_TRIM_SEL_O,
   output logic RATE_DETECT_EN_O
);
   localparam int TRIM_BOUND = 66;

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   logic pdn_meta_reg;
   logic pdn_sync_reg;
   always_ff @(posedge REF_CLK_I) begin
      pdn_meta_reg <= POWER_DOWN_INPUT_I;
      pdn_sync_reg <= pdn_meta_reg;
   end

   // ----------------------------------------
   // register file
   // ----------------------------------------
   reg_byte_type group_reg;
   reg_byte_type period_reg;
   reg_byte_type trim_reg;
   logic trim_done_reg;
   logic [7:0] trim_cnt_reg;
   wire wr_group = REG_WR_I && (REG_ADDR_I == `ADDR_SHUTDOWN_GROUP);
   wire wr_period = REG_WR_I && (REG_ADDR_I == `ADDR_SOFT_PERIOD);
   wire wr_trim = REG_WR_I && (REG_ADDR_I == `ADDR_OSC_TRIM);
   wire trim_last = !trim_done_reg && (trim_cnt_reg == 8'h01);
   wire [7:0] trim_view = {trim_reg[7], trim_done_reg, trim_reg[5:0]}; // RULE10
   wire [7:0] rd_mux = (REG_ADDR_I == `ADDR_SHUTDOWN_GROUP) ? group_reg :
                       (REG_ADDR_I == `ADDR_SOFT_PERIOD) ? period_reg :
                       (REG_ADDR_I == `ADDR_OSC_TRIM) ? trim_view : 8'h00;
   wire factory_sel = !trim_reg[`BIT_FACTORY_OFF]; // RULE8 RULE11

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         group_reg <= `RST_SHUTDOWN_GROUP;
         period_reg <= `RST_SOFT_PERIOD; // RULE5
         trim_reg <= `RST_OSC_TRIM; // RULE11
         REG_RDATA_O <= 8'h00;
      end else begin
         if (wr_group)
            group_reg <= REG_WDATA_I; // RULE1
         if (wr_period)
            period_reg <= REG_WDATA_I;
         if (wr_trim)
            trim_reg <= REG_WDATA_I & 8'hBF;
         if (REG_RD_I)
            REG_RDATA_O <= rd_mux;
      end
   end

   // ----------------------------------------
   // oscillator trim engine
   // ----------------------------------------
   // trim restarts on every write, so a stale done never survives a new trim
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         trim_done_reg <= 1'b0;
         trim_cnt_reg <= 8'h00;
         OSC_TRIM_O <= 8'h00;
         FACTORY_TRIM_SEL_O <= 1'b0;
         RATE_DETECT_EN_O <= 1'b0;
      end else begin
         if (wr_trim) begin
            trim_done_reg <= 1'b0;
            trim_cnt_reg <= `TRIM_CYCLES;
         end else if (trim_last) begin
            trim_done_reg <= 1'b1; // RULE10
         end else if (!trim_done_reg && trim_cnt_reg != 8'h00) begin
            trim_cnt_reg <= trim_cnt_reg - 8'h01;
         end
         OSC_TRIM_O <= factory_sel ? FACTORY_TRIM_I : DEFAULT_TRIM; // RULE8
         FACTORY_TRIM_SEL_O <= factory_sel;
         RATE_DETECT_EN_O <= trim_done_reg; // RULE7 RULE9
      end
   end

   // ----------------------------------------
   // shutdown sequencer
   // ----------------------------------------
   ramp_if rif ();
   seq_state_type state_reg;
   seq_state_type state_next;
   logic [3:0] start_mask_reg;
   wire shut_now = ALL_SHUTDOWN_I || pdn_sync_reg; // RULE3
   wire [3:0] start_mask = HOLD_GROUP_I ? 4'hF : ~group_reg[3:0]; // RULE2
   wire go_up = (state_reg == ST_DOWN) && !shut_now;
   wire go_down = (state_reg == ST_RUN) && shut_now;
   // codes 0..7 end at once, so no half-duty cycle may leak out for them
   wire no_ramp_now = rif.skip || (period_reg[4:3] == 2'h0); // RULE4
   wire ramp_next = (state_next == ST_RAMP_UP) || (state_next == ST_RAMP_DOWN);
   // a ramp always completes; a shutdown change mid-ramp is served afterwards
   always_comb begin
      case (state_reg)
         ST_DOWN: state_next = go_up ? ST_RAMP_UP : ST_DOWN;
         ST_RAMP_UP: state_next = rif.done ? ST_RUN : ST_RAMP_UP;
         ST_RUN: state_next = go_down ? ST_RAMP_DOWN : ST_RUN;
         ST_RAMP_DOWN: state_next = rif.done ? ST_DOWN : ST_RAMP_DOWN;
         default: state_next = ST_DOWN;
      endcase
   end

   assign rif.start = go_up || go_down; // RULE3
   assign rif.skip = period_reg[`BIT_TIMER_DISABLE] ||
                     (period_reg[4:2] == `SKIP_CODE_TOP); // RULE4
   assign rif.code = period_reg[4:0];

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         state_reg <= ST_DOWN;
         start_mask_reg <= 4'h0;
         CH_RUN_O <= 4'h0;
         HALF_DUTY_O <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (go_up)
            start_mask_reg <= start_mask; // RULE2
         CH_RUN_O <= (state_next == ST_DOWN) ? 4'h0 : (go_up ? start_mask : start_mask_reg);
         HALF_DUTY_O <= ramp_next && !(rif.start && no_ramp_now); // RULE4
      end
   end

   soft_ramp_timer #(
      .CYCLES_PER_TENTH(CYCLES_PER_TENTH)
   ) u_timer (
      .clk_i(REF_CLK_I),
      .reset_i(RESET_I),
      .rif(rif.timer)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);

   sequence s_leave_shutdown;
      go_up && !HOLD_GROUP_I;
   endsequence
   sequence s_members_stopped;
      CH_RUN_O == ~group_reg[3:0];
   endsequence

   property p_group_held;
      s_leave_shutdown ##0 (!wr_group) |=> s_members_stopped;
   endproperty
   a_group_held: assert property (p_group_held) else $error("group member started"); // RULE2

   property p_mask_bits;
      (go_up && HOLD_GROUP_I) |=> (CH_RUN_O == 4'hF);
   endproperty
   a_mask_bits: assert property (p_mask_bits) else $error("hold set but channel missing"); // RULE1

   property p_ramp_on_shutdown;
      go_down |=> (state_reg == ST_RAMP_DOWN) ##1 (state_reg != ST_RUN);
   endproperty
   a_ramp_on_shutdown: assert property (p_ramp_on_shutdown) else $error("no soft stop"); // RULE3

   property p_skip_fast;
      (go_up && rif.skip) |-> ##[1:3] (state_reg == ST_RUN);
   endproperty
   a_skip_fast: assert property (p_skip_fast) else $error("skip took too long"); // RULE4

   property p_trim_clears;
      wr_trim |=> !trim_done_reg;
   endproperty
   a_trim_clears: assert property (p_trim_clears) else $error("done not cleared"); // RULE10

   property p_trim_finishes;
      wr_trim ##1 (!wr_trim)[*8] |-> ##[1:TRIM_BOUND] trim_done_reg;
   endproperty
   a_trim_finishes: assert property (p_trim_finishes) else $error("trim never done"); // RULE10

   property p_factory_select;
      (wr_trim && REG_WDATA_I == 8'h00) |=> ##1 (FACTORY_TRIM_SEL_O &&
         OSC_TRIM_O == $past(FACTORY_TRIM_I));
   endproperty
   a_factory_select: assert property (p_factory_select) else $error("factory trim unused"); // RULE8

   property p_read_done;
      (REG_RD_I && REG_ADDR_I == `ADDR_OSC_TRIM) |=> (REG_RDATA_O[6] == $past(trim_done_reg));
   endproperty
   a_read_done: assert property (p_read_done) else $error("done flag misread"); // RULE10

   property p_rate_gate;
      RATE_DETECT_EN_O |-> $past(trim_done_reg);
   endproperty
   a_rate_gate: assert property (p_rate_gate) else $error("rate detect before trim"); // RULE7

   property p_half_on_ramp;
      (rif.start && !no_ramp_now) |=> HALF_DUTY_O;
   endproperty
   a_half_on_ramp: assert property (p_half_on_ramp) else $error("no half duty on ramp"); // RULE3

   property p_half_skipped;
      (rif.start && no_ramp_now) |=> !HALF_DUTY_O ##1 !HALF_DUTY_O;
   endproperty
   a_half_skipped: assert property (p_half_skipped) else $error("half duty on skip"); // RULE4

   property p_down_idle;
      (state_reg == ST_RAMP_DOWN && rif.done) |=> (CH_RUN_O == 4'h0) && !HALF_DUTY_O;
   endproperty
   a_down_idle: assert property (p_down_idle) else $error("channels left running"); // RULE3
endmodule

// *** core/ramp_if.sv ***
interface ramp_if;
   logic start;
   logic skip;
   logic [4:0] code;
   logic busy;
   logic done;
   modport ctrl (output start, output skip, output code, input busy, input done);
   modport timer (input start, input skip, input code, output busy, output done);
endinterface

// *** core/soft_ramp_timer.sv ***
`include "pwm_ctrl_consts.svh"
module soft_ramp_timer
   import pwm_ctrl_pkg::*;
#(
   parameter int unsigned CYCLES_PER_TENTH = 2000
) (
   input wire logic clk_i,
   input wire logic reset_i,
   ramp_if.timer rif
);
   // ----------------------------------------
   // code to length lookup
   // ----------------------------------------
   tenths_type len_sel;
   always_comb begin
      case (rif.code)
         5'h08: len_sel = `SS_T08;
         5'h09: len_sel = `SS_T09;
         5'h0A: len_sel = `SS_T0A;
         5'h0B: len_sel = `SS_T0B;
         5'h0C: len_sel = `SS_T0C;
         5'h0D: len_sel = `SS_T0D;
         5'h0E: len_sel = `SS_T0E;
         5'h0F: len_sel = `SS_T0F; // RULE5
         5'h10: len_sel = `SS_T10;
         5'h11: len_sel = `SS_T11;
         5'h12: len_sel = `SS_T12;
         5'h13: len_sel = `SS_T13;
         5'h14: len_sel = `SS_T14;
         5'h15: len_sel = `SS_T15;
         5'h16: len_sel = `SS_T16;
         5'h17: len_sel = `SS_T17;
         5'h18: len_sel = `SS_T18;
         5'h19: len_sel = `SS_T19;
         5'h1A: len_sel = `SS_T1A;
         5'h1B: len_sel = `SS_T1B;
         5'h1C: len_sel = `SS_T1C;
         5'h1D: len_sel = `SS_T1D;
         5'h1E: len_sel = `SS_T1E;
         5'h1F: len_sel = `SS_T1F; // RULE6
         default: len_sel = 18'h00000;
      endcase
   end

   // ----------------------------------------
   // prescaler and tenths counter
   // ----------------------------------------
   logic [15:0] pre_reg;
   tenths_type left_reg;
   logic busy_reg;
   logic done_reg;
   wire no_ramp = rif.skip || (len_sel == 18'h00000); // RULE4
   wire pre_wrap = (pre_reg == 16'(CYCLES_PER_TENTH - 1));
   wire last_tick = busy_reg && pre_wrap && (left_reg == 18'h00001);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pre_reg <= 16'h0000;
         left_reg <= 18'h00000;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (rif.start) begin
         pre_reg <= 16'h0000;
         left_reg <= len_sel;
         busy_reg <= !no_ramp;
         done_reg <= no_ramp;
      end else begin
         pre_reg <= (busy_reg && !pre_wrap) ? pre_reg + 16'h0001 : 16'h0000;
         left_reg <= (busy_reg && pre_wrap) ? left_reg - 18'h00001 : left_reg;
         busy_reg <= busy_reg && !last_tick;
         done_reg <= last_tick;
      end
   end
   assign rif.busy = busy_reg;
   assign rif.done = done_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_skip_done;
      @(posedge clk_i) disable iff (reset_i)
      (rif.start && rif.skip) |=> (done_reg && !busy_reg);
   endproperty
   a_skip_done: assert property (p_skip_done) else $error("skip did not finish at once"); // RULE4

   property p_done_after_busy;
      @(posedge clk_i) disable iff (reset_i)
      (done_reg && !$past(rif.start)) |-> ($past(busy_reg) && !busy_reg);
   endproperty
   a_done_after_busy: assert property (p_done_after_busy) else $error("done without ramp"); // RULE5
endmodule

// *** tb/testbench.sv ***
`include "pwm_ctrl_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pwm_ctrl_pkg::*;

   // ---------------------------------------
   // short ramps: two cycles per tenth ms
   // ---------------------------------------
   localparam int unsigned CPT = 2;
   localparam logic [7:0] DEF_TRIM = 8'h5A; // arbitrary value

   logic ref_clk = 1'b0;
   logic reset, wr, rd, all_sd, hold, power_down_input, half, fsel, rate_en;
   logic rd_q = 1'b0;
   logic [7:0] addr, wdata, rdata, ftrim, osc_trim;
   logic [3:0] ch_run, grp;
   reg_byte_type exp_q[$];
   int errors = 0;
   int samples_checked = 0;
   int seed = 15;

   always #25 ref_clk = ~ref_clk;

   pwm_shutdown_softstart_trim #(.CYCLES_PER_TENTH(CPT), .DEFAULT_TRIM(DEF_TRIM)) i_dut (
      .REF_CLK_I(ref_clk), .RESET_I(reset), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .ALL_SHUTDOWN_I(all_sd),
      .HOLD_GROUP_I(hold), .POWER_DOWN_INPUT_I(power_down_input), .FACTORY_TRIM_I(ftrim),
      .CH_RUN_O(ch_run), .HALF_DUTY_O(half), .OSC_TRIM_O(osc_trim),
      .FACTORY_TRIM_SEL_O(fsel), .RATE_DETECT_EN_O(rate_en));

   task automatic end_sim();
      if (errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_rd(input logic [7:0] got);
      logic [7:0] e;
      e = exp_q.pop_front();
      cmp_out(got, e);
   endtask

   // ---------------------------------------
   // read data lands one edge after the read
   // ---------------------------------------
   always @(posedge ref_clk) begin
      if (rd_q) begin
         cmp_rd(rdata);
      end
      rd_q <= rd;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
   endtask

   // n = ramp cycles, 0 when the half-duty interval is skipped
   task automatic ramp(input logic sd, input int n, input logic [3:0] mask);
      @(posedge ref_clk);
      all_sd <= sd;
      tick(1);
      cmp_out({4'h0, ch_run}, {4'h0, mask});
      cmp_out({7'h0, half}, {7'h0, (n > 0)});
      if (n > 0) begin
         tick(n);
         cmp_out({7'h0, half}, 8'h01);
      end
      tick(2);
      cmp_out({7'h0, half}, 8'h00);
      cmp_out({4'h0, ch_run}, sd ? 8'h00 : {4'h0, mask});
   endtask

   initial begin
      #(20000 * 50);
      errors++;
      end_sim();
   end

   initial begin
      int k;
      reset = 1'b1;
      all_sd = 1'b1;
      hold = 1'b0;
      power_down_input = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ftrim = 8'($random(seed));
      grp = 4'($random(seed));
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      tick(3);
      cmp_out(osc_trim, DEF_TRIM);
      cmp_out({7'h0, fsel}, 8'h00);
      cmp_out({7'h0, rate_en}, 8'h00);
      rd_reg(`ADDR_SHUTDOWN_GROUP, `RST_SHUTDOWN_GROUP);
      rd_reg(`ADDR_SOFT_PERIOD, `RST_SOFT_PERIOD);
      rd_reg(`ADDR_OSC_TRIM, `RST_OSC_TRIM);
      rd_reg(8'h1C, 8'h00);
      wr_reg(8'h1C, 8'hFF);
      rd_reg(`ADDR_SHUTDOWN_GROUP, `RST_SHUTDOWN_GROUP);
      // -------------------------------------
      // trim: done bit cannot be written
      // -------------------------------------
      wr_reg(`ADDR_OSC_TRIM, 8'h00);
      rd_reg(`ADDR_OSC_TRIM, 8'h00);
      wr_reg(`ADDR_OSC_TRIM, 8'hC2);
      rd_reg(`ADDR_OSC_TRIM, 8'h82);
      tick(3);
      cmp_out({7'h0, fsel}, 8'h00);
      cmp_out(osc_trim, DEF_TRIM);
      tick(59);
      cmp_out({7'h0, rate_en}, 8'h00);
      tick(3);
      cmp_out({7'h0, rate_en}, 8'h01);
      rd_reg(`ADDR_OSC_TRIM, 8'hC2);
      wr_reg(`ADDR_OSC_TRIM, 8'h00);
      tick(2);
      cmp_out({7'h0, fsel}, 8'h01);
      cmp_out(osc_trim, ftrim);
      tick(70);
      rd_reg(`ADDR_OSC_TRIM, 8'h40);
      // -------------------------------------
      // sequencer with group and period codes
      // -------------------------------------
      wr_reg(`ADDR_SHUTDOWN_GROUP, {4'h3, grp});
      rd_reg(`ADDR_SHUTDOWN_GROUP, {4'h3, grp});
      wr_reg(`ADDR_SOFT_PERIOD, 8'h68);
      ramp(1'b0, 165 * CPT, ~grp);
      ramp(1'b1, 165 * CPT, ~grp);
      @(posedge ref_clk);
      hold <= 1'b1;
      wr_reg(`ADDR_SOFT_PERIOD, 8'h64);
      ramp(1'b0, 0, 4'hF);
      ramp(1'b1, 0, 4'hF);
      @(posedge ref_clk);
      hold <= 1'b0;
      wr_reg(`ADDR_SOFT_PERIOD, 8'hE8);
      ramp(1'b0, 0, ~grp);
      wr_reg(`ADDR_SOFT_PERIOD, 8'h70);
      ramp(1'b1, 1646 * CPT, ~grp);
      // -------------------------------------
      // power-down pin goes through a sync
      // -------------------------------------
      wr_reg(`ADDR_SOFT_PERIOD, 8'h64);
      @(posedge ref_clk);
      power_down_input <= 1'b1;
      repeat (3) @(posedge ref_clk);
      all_sd <= 1'b0;
      tick(10);
      cmp_out({4'h0, ch_run}, 8'h00);
      @(posedge ref_clk);
      power_down_input <= 1'b0;
      for (k = 0; k < 10 && ch_run === 4'h0; k++) begin
         tick(1);
      end
      cmp_out({4'h0, ch_run}, {4'h0, ~grp});
      @(posedge ref_clk);
      power_down_input <= 1'b1;
      for (k = 0; k < 10 && ch_run !== 4'h0; k++) begin
         tick(1);
      end
      cmp_out({4'h0, ch_run}, 8'h00);
      // -------------------------------------
      // reset in mid-run drops the trim
      // -------------------------------------
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      tick(2);
      cmp_out({7'h0, rate_en}, 8'h00);
      cmp_out(osc_trim, DEF_TRIM);
      rd_reg(`ADDR_OSC_TRIM, `RST_OSC_TRIM);
      tick(3);
      end_sim();
   end
endmodule
